// >>> logic/pcm_regs.svh
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCM_ADDR_POWER_MODE 8'h00
`define PCM_ADDR_EXT_INT_FLAG 8'h01
`define PCM_ADDR_STATUS 8'h02
`define PCM_ADDR_POWER_CONTROL 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCM_PMR_DIV_HI 7
`define PCM_PMR_DIV_LO 6
`define PCM_PMR_SWB 5
`define PCM_PMR_CRYSTAL_AMP_OFF 3
`define PCM_EXT_INT_FLAG_REG_SRC_SEL 3
`define PCM_EXT_INT_FLAG_REG_RC_ACTIVE 2
`define PCM_EXT_INT_FLAG_REG_RC_WAKE 1
`define PCM_STATUS_XREADY 4
`define PCM_POWER_CONTROL_REG_IDLE 0
`define PCM_POWER_CONTROL_REG_PD 1

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define PCM_DIV_RSV 2'h0
`define PCM_DIV_4 2'h1
`define PCM_DIV_64 2'h2
`define PCM_DIV_1024 2'h3
`define PCM_SRC_CRYSTAL 1'h1
`define PCM_SRC_RC 1'h0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
// prescale limit per state, clocks per state minus one
`define PCM_STATE_LIM_4 8'h00
`define PCM_STATE_LIM_64 8'h0F
`define PCM_STATE_LIM_1024 8'hFF
`define PCM_CLK_PERIOD_NS 50
`define PCM_XTAL_WARM_NS 100000
`define PCM_XTAL_WARM_CYC \
  ((`PCM_XTAL_WARM_NS + `PCM_CLK_PERIOD_NS - 1) / `PCM_CLK_PERIOD_NS)
`define PCM_RST_HOLD_CYC 2'h2
`define PCM_APPLY_DELAY 2'h2

`endif

// >>> logic/pcm_pkg.sv
package pcm_pkg;

  typedef enum logic [3:0] {
    PCM_ST_RUN = 4'b0001,
    PCM_ST_PD = 4'b0010,
    PCM_ST_WAKE_XT = 4'b0100,
    PCM_ST_WAKE_RC = 4'b1000
  } pcm_mode_t;

  typedef struct packed {
    logic [7:0] presc;
    logic [1:0] phase;
    logic state_tick;
    logic fourth;
  } pcm_gen_state_t;

  typedef struct packed {
    pcm_mode_t mode;
    logic [1:0] div;
    logic [1:0] div_pend;
    logic [1:0] div_cnt;
    logic switchback_enable;
    logic crystal_amp_off;
    logic src;
    logic src_pend;
    logic use_rc;
    logic [1:0] src_cnt;
    logic rc_wake;
    logic idle;
    logic pd_req;
    logic [11:0] warm_cnt;
    logic xready;
    logic rst_active;
    logic [1:0] rst_hold;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic rp_s1;
    logic rp_s2;
    logic [1:0] int_s1;
    logic [1:0] int_s2;
    logic [7:0] rdata;
    logic cpu_en;
    logic periph_en;
    logic amp_en;
    logic strobe_low;
    logic strobe_high;
    logic p0_float;
    logic [1:0] wake_int;
  } pcm_ctrl_state_t;

endpackage

// >>> logic/pcm_cyc_if.sv
`timescale 1ns/1ns
interface pcm_cyc_if;
  logic [1:0] div_sel;
  logic run;
  logic state_tick;
  logic fourth_state;

  modport ctrl (
    output div_sel,
    output run,
    input state_tick,
    input fourth_state
  );

  modport gen (
    input div_sel,
    input run,
    output state_tick,
    output fourth_state
  );
endinterface

// >>> logic/pcm_cycle_gen.sv
`timescale 1ns/1ns
`include "pcm_regs.svh"
module pcm_cycle_gen
  import pcm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  pcm_cyc_if.gen cyc
);

  pcm_gen_state_t q, d;
  logic [7:0] lim;

  // ----------------------------------------------------------------
  // state sequencer: four states per machine cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.state_tick = 1'b0;
    d.fourth = 1'b0;
    unique case (cyc.div_sel)
      `PCM_DIV_64: lim = `PCM_STATE_LIM_64;
      `PCM_DIV_1024: lim = `PCM_STATE_LIM_1024;
      default: lim = `PCM_STATE_LIM_4;
    endcase
    if (!cyc.run)
    begin
      d.presc = 8'h00;
      d.phase = 2'h0;
    end
    // >= so a switch to a faster rate mid-state never overruns
    else if (q.presc >= lim)
    begin
      d.presc = 8'h00;
      d.state_tick = 1'b1;
      d.fourth = (q.phase == 2'h3);
      d.phase = q.phase + 2'h1;
    end
    else
    begin
      d.presc = q.presc + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign cyc.state_tick = q.state_tick;
  assign cyc.fourth_state = q.fourth;

endmodule

// >>> logic/pcm_ctrl.sv
`timescale 1ns/1ns
`include "pcm_regs.svh"
module pcm_ctrl
  import pcm_pkg::*;
#(
  parameter logic [11:0] XTAL_WARM_CYC = 12'(`PCM_XTAL_WARM_CYC)
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  input wire logic instr_end,
  input wire logic serial_busy,
  input wire logic rx_enable,
  input wire logic rx_pin,
  input wire logic tx_buf_write,
  input wire logic ext_int_ack,
  input wire logic int_pending,
  input wire logic rst_pin,
  input wire logic [1:0] ext_int_n_pin,
  input wire logic [1:0] int_level_mode,
  input wire logic [1:0] int_enable,
  input wire logic global_int_enable,
  input wire logic ext_prog_mem,
  input wire logic wdt_reset_req,
  output logic cpu_clk_en_q,
  output logic periph_clk_en_q,
  output logic osc_use_rc_q,
  output logic crystal_amp_en_q,
  output logic sys_reset_q,
  output logic power_down_q,
  output logic strobe_force_low_q,
  output logic strobe_force_high_q,
  output logic port0_float_q,
  output logic [1:0] wake_int_q
);

  pcm_ctrl_state_t q, d;
  pcm_cyc_if cyc ();

  logic wr_pmr;
  logic wr_ext_int_flag_reg;
  logic wr_power_control_reg;
  logic switchback;
  logic [1:0] wake_pins;
  logic cyc_end;
  logic amp_on;
  logic rx_fall;

  pcm_cycle_gen u_gen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .cyc(cyc)
  );

  assign cyc.div_sel = q.div;
  // the sequencer only runs while the core owns a live clock
  assign cyc.run = (q.mode == PCM_ST_RUN) || (q.mode == PCM_ST_WAKE_RC);
  assign cyc_end = cyc.fourth_state;

  // ----------------------------------------------------------------
  // decode and event terms
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_pmr = wr && (addr == `PCM_ADDR_POWER_MODE);
    wr_ext_int_flag_reg = wr && (addr == `PCM_ADDR_EXT_INT_FLAG);
    wr_power_control_reg = wr && (addr == `PCM_ADDR_POWER_CONTROL);
    rx_fall = q.rx_prev && !q.rx_s2;
    // interrupt flags are not looked at here on purpose
    switchback = q.switchback_enable && (ext_int_ack || (rx_enable && rx_fall) || tx_buf_write);
    wake_pins = ~q.int_s2 & int_level_mode & int_enable & {2{global_int_enable}};
    // amplifier drops in power-down, or when amp-off is set and RC really drives the clock
    amp_on = (q.mode != PCM_ST_PD) && !(q.crystal_amp_off && (q.src == `PCM_SRC_RC));
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.wake_int = 2'h0;
    d.rx_s1 = rx_pin;
    d.rx_s2 = q.rx_s1;
    d.rx_prev = q.rx_s2;
    d.rp_s1 = rst_pin;
    d.rp_s2 = q.rp_s1;
    d.int_s1 = ext_int_n_pin;
    d.int_s2 = q.int_s1;

    // crystal warm-up
    if (!amp_on)
    begin
      d.warm_cnt = 12'h000;
      d.xready = 1'b0;
    end
    else if (q.warm_cnt >= XTAL_WARM_CYC - 12'h001)
    begin
      d.xready = 1'b1;
    end
    else
    begin
      d.warm_cnt = q.warm_cnt + 12'h001;
    end

    // software writes
    if (wr_pmr)
    begin
      d.switchback_enable = wdata[`PCM_PMR_SWB];
      d.crystal_amp_off = wdata[`PCM_PMR_CRYSTAL_AMP_OFF];
      if (wdata[`PCM_PMR_DIV_HI:`PCM_PMR_DIV_LO] != `PCM_DIV_RSV
          && !(q.switchback_enable && serial_busy))
      begin
        d.div_pend = wdata[`PCM_PMR_DIV_HI:`PCM_PMR_DIV_LO];
        d.div_cnt = `PCM_APPLY_DELAY;
      end
    end
    if (wr_ext_int_flag_reg)
    begin
      d.rc_wake = wdata[`PCM_EXT_INT_FLAG_REG_RC_WAKE];
      if (!(wdata[`PCM_EXT_INT_FLAG_REG_SRC_SEL] && !q.xready))
      begin
        d.src_pend = wdata[`PCM_EXT_INT_FLAG_REG_SRC_SEL];
        d.src_cnt = `PCM_APPLY_DELAY;
      end
    end
    if (wr_power_control_reg)
    begin
      d.idle = wdata[`PCM_POWER_CONTROL_REG_IDLE];
      d.pd_req = wdata[`PCM_POWER_CONTROL_REG_PD];
    end

    // delayed application at machine-cycle boundaries
    if (cyc_end && q.div_cnt != 2'h0)
    begin
      d.div_cnt = q.div_cnt - 2'h1;
      if (q.div_cnt == 2'h1)
        d.div = q.div_pend;
    end
    if (cyc_end && q.src_cnt != 2'h0)
    begin
      d.src_cnt = q.src_cnt - 2'h1;
      if (q.src_cnt == 2'h1)
        d.src = q.src_pend;
    end

    // switchback overrides any pending slow setting
    if (switchback)
    begin
      d.div = `PCM_DIV_4;
      d.div_cnt = 2'h0;
    end

    // any enabled interrupt ends idle
    if (int_pending)
      d.idle = 1'b0;

    // external reset, sampled once per machine cycle
    if (cyc_end && q.rp_s2)
    begin
      d.rst_active = 1'b1;
      d.rst_hold = `PCM_RST_HOLD_CYC;
    end
    else if (cyc_end && q.rst_active)
    begin
      if (q.rst_hold <= 2'h1)
        d.rst_active = 1'b0;
      d.rst_hold = q.rst_hold - 2'h1;
    end
    if (wdt_reset_req)
    begin
      d.rst_active = 1'b1;
      d.rst_hold = `PCM_RST_HOLD_CYC;
    end

    // mode sequencing
    unique case (q.mode)
      PCM_ST_RUN:
      begin
        if (q.pd_req && instr_end && !q.rst_active)
          d.mode = PCM_ST_PD;
      end
      PCM_ST_PD:
      begin
        // the sequencer is frozen here, so the pin is watched directly
        if (q.rp_s2 || wake_pins != 2'h0)
        begin
          d.pd_req = 1'b0;
          if (q.rp_s2)
          begin
            d.rst_active = 1'b1;
            d.rst_hold = `PCM_RST_HOLD_CYC;
          end
          else
          begin
            d.wake_int = wake_pins;
          end
          if (q.src == `PCM_SRC_RC)
            d.mode = PCM_ST_RUN;
          else if (q.rc_wake)
          begin
            d.src = `PCM_SRC_RC;
            d.src_cnt = 2'h0;
            d.mode = PCM_ST_WAKE_RC;
          end
          else
            d.mode = PCM_ST_WAKE_XT;
        end
      end
      PCM_ST_WAKE_XT:
      begin
        if (q.xready)
          d.mode = PCM_ST_RUN;
      end
      PCM_ST_WAKE_RC:
      begin
        if (q.xready)
        begin
          d.src = `PCM_SRC_CRYSTAL;
          d.mode = PCM_ST_RUN;
        end
      end
    endcase

    // soft reset of the divider, switchback, idle, power-down and RC-wake bits from watchdog or pin
    if (q.rst_active)
    begin
      d.div = `PCM_DIV_4;
      d.div_cnt = 2'h0;
      d.switchback_enable = 1'b0;
      d.idle = 1'b0;
      d.pd_req = 1'b0;
      d.rc_wake = 1'b0;
    end

    // clock enables: core and peripherals
    d.cpu_en = cyc.state_tick && !q.idle && (q.mode != PCM_ST_PD)
      && (q.mode != PCM_ST_WAKE_XT);
    // idle peripherals keep the full clock/4 cadence, one state per clock
    if (q.idle)
      d.periph_en = cyc.run;
    else
      d.periph_en = cyc.state_tick;

    d.amp_en = amp_on;
    // registered copy so the status pin has no gate behind the flop
    d.use_rc = (d.src == `PCM_SRC_RC);
    d.strobe_low = (d.mode == PCM_ST_PD);
    d.strobe_high = q.idle && (d.mode == PCM_ST_RUN);
    d.p0_float = (d.mode == PCM_ST_PD) && ext_prog_mem;

    // register reads, answered in the next cycle
    d.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        `PCM_ADDR_POWER_MODE:
        begin
          d.rdata[`PCM_PMR_DIV_HI:`PCM_PMR_DIV_LO] = q.div;
          d.rdata[`PCM_PMR_SWB] = q.switchback_enable;
          d.rdata[`PCM_PMR_CRYSTAL_AMP_OFF] = q.crystal_amp_off;
        end
        `PCM_ADDR_EXT_INT_FLAG:
        begin
          d.rdata[`PCM_EXT_INT_FLAG_REG_SRC_SEL] = q.src;
          d.rdata[`PCM_EXT_INT_FLAG_REG_RC_ACTIVE] = (q.src == `PCM_SRC_RC);
          d.rdata[`PCM_EXT_INT_FLAG_REG_RC_WAKE] = q.rc_wake;
        end
        `PCM_ADDR_STATUS:
          d.rdata[`PCM_STATUS_XREADY] = q.xready;
        `PCM_ADDR_POWER_CONTROL:
        begin
          d.rdata[`PCM_POWER_CONTROL_REG_IDLE] = q.idle;
          d.rdata[`PCM_POWER_CONTROL_REG_PD] = q.pd_req;
        end
        default:
          d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.mode <= PCM_ST_RUN;
      q.div <= `PCM_DIV_4;
      q.div_pend <= `PCM_DIV_4;
      q.src <= `PCM_SRC_CRYSTAL;
      q.src_pend <= `PCM_SRC_CRYSTAL;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.rx_prev <= 1'b1;
      q.int_s1 <= 2'h3;
      q.int_s2 <= 2'h3;
      q.amp_en <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from the state register
  // ----------------------------------------------------------------
  assign rdata_q = q.rdata;
  assign cpu_clk_en_q = q.cpu_en;
  assign periph_clk_en_q = q.periph_en;
  assign osc_use_rc_q = q.use_rc;
  assign crystal_amp_en_q = q.amp_en;
  assign sys_reset_q = q.rst_active;
  assign power_down_q = q.strobe_low;
  assign strobe_force_low_q = q.strobe_low;
  assign strobe_force_high_q = q.strobe_high;
  assign port0_float_q = q.p0_float;
  assign wake_int_q = q.wake_int;

endmodule

// >>> dv/pcm_ctrl_properties.sv
`timescale 1ns/1ns
module pcm_ctrl_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rd,
  input wire logic instr_end,
  input wire logic ext_prog_mem,
  input wire logic [7:0] rdata_q,
  input wire logic cpu_clk_en_q,
  input wire logic periph_clk_en_q,
  input wire logic crystal_amp_en_q,
  input wire logic power_down_q,
  input wire logic strobe_force_low_q,
  input wire logic strobe_force_high_q,
  input wire logic port0_float_q,
  input wire logic [1:0] wake_int_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !rd |=> rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_pd_entry; $rose(power_down_q) |-> $past(instr_end); endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down without end");
  property p_pd_pins; power_down_q [*2] |-> strobe_force_low_q && !cpu_clk_en_q; endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("power-down strobes");
  property p_pd_float; power_down_q [*2] |-> port0_float_q == $past(ext_prog_mem); endproperty
  a_pd_float: assert property (p_pd_float) else $error("port 0 float wrong");
  property p_pd_amp; power_down_q [*3] |-> !crystal_amp_en_q && !periph_clk_en_q; endproperty
  a_pd_amp: assert property (p_pd_amp) else $error("clock alive in power-down");
  property p_wake_pulse; wake_int_q != 2'h0 |=> wake_int_q == 2'h0 && !power_down_q; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_wake_cause; wake_int_q != 2'h0 |-> $past(power_down_q); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake outside power-down");
  property p_idle_core; strobe_force_high_q && $past(strobe_force_high_q) |-> !cpu_clk_en_q;
  endproperty
  a_idle_core: assert property (p_idle_core) else $error("core clocked in idle");
  property p_idle_periph; strobe_force_high_q [*2] |-> periph_clk_en_q; endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("peripherals slow in idle");
endmodule

bind pcm_ctrl pcm_ctrl_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .rd(rd), .instr_end(instr_end),
  .ext_prog_mem(ext_prog_mem), .rdata_q(rdata_q), .cpu_clk_en_q(cpu_clk_en_q),
  .periph_clk_en_q(periph_clk_en_q), .crystal_amp_en_q(crystal_amp_en_q),
  .power_down_q(power_down_q), .strobe_force_low_q(strobe_force_low_q),
  .strobe_force_high_q(strobe_force_high_q), .port0_float_q(port0_float_q),
  .wake_int_q(wake_int_q)
);

// >>> dv/pcm_ctrl_bench.sv
`timescale 1ns/1ns
module pcm_ctrl_bench;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic rc; logic amp;}
    pcm_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, instr_end = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_q;
  logic serial_busy = 1'b0, rx_enable = 1'b0, rx_pin = 1'b1, tx_buf_write = 1'b0;
  logic ext_int_ack = 1'b0, int_pending = 1'b0, rst_pin = 1'b0, global_int_enable = 1'b0;
  logic ext_prog_mem = 1'b0, wdt_reset_req = 1'b0, w_rc, w_rst, ce = 1'b1;
  logic [1:0] ext_int_n_pin = 2'h3, int_level_mode = 2'h0, int_enable = 2'h0, wake_int_q, w_int;
  logic cpu_clk_en_q, periph_clk_en_q, osc_use_rc_q, crystal_amp_en_q, sys_reset_q;
  logic power_down_q, strobe_force_low_q, strobe_force_high_q, port0_float_q;
  int mismatches = 0, checks = 0;
  // divider codes walk through divide-by-4 between slow rates, as software must
  logic [7:0] dv [4] = '{8'h80, 8'h40, 8'hC0, 8'h40};
  int old_gap [4] = '{1, 16, 1, 256};
  int new_gap [4] = '{16, 1, 256, 1};
  pcm_row_t rows [6] = '{'{8'h00, 8'h48, 8'h48, 1'b1, 1'b0}, '{8'h00, 8'h40, 8'h40, 1'b1, 1'b1},
    '{8'h01, 8'h08, 8'h08, 1'b0, 1'b1}, '{8'h00, 8'h00, 8'h40, 1'b0, 1'b1},
    '{8'h03, 8'h00, 8'h00, 1'b0, 1'b1}, '{8'h04, 8'hFF, 8'h00, 1'b0, 1'b1}};

  always #25 core_clk = ~core_clk;

  pcm_ctrl #(.XTAL_WARM_CYC(12'h028)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .instr_end(instr_end), .serial_busy(serial_busy),
    .rx_enable(rx_enable), .rx_pin(rx_pin), .tx_buf_write(tx_buf_write),
    .ext_int_ack(ext_int_ack), .int_pending(int_pending), .rst_pin(rst_pin),
    .ext_int_n_pin(ext_int_n_pin), .int_level_mode(int_level_mode), .int_enable(int_enable),
    .global_int_enable(global_int_enable), .ext_prog_mem(ext_prog_mem),
    .wdt_reset_req(wdt_reset_req), .cpu_clk_en_q(cpu_clk_en_q),
    .periph_clk_en_q(periph_clk_en_q), .osc_use_rc_q(osc_use_rc_q),
    .crystal_amp_en_q(crystal_amp_en_q), .sys_reset_q(sys_reset_q),
    .power_down_q(power_down_q), .strobe_force_low_q(strobe_force_low_q),
    .strobe_force_high_q(strobe_force_high_q), .port0_float_q(port0_float_q),
    .wake_int_q(wake_int_q));

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    #1 chk(nm, rdata_q, e);
    tick(1);
  endtask

  // clocks between two core pulses; a missing pulse gives up after 600
  task automatic gap(input string nm, input int e);
    int n;
    for (n = 0; n < 600 && cpu_clk_en_q !== 1'b1; n++) tick(1);
    tick(1);
    for (n = 1; n < 600 && cpu_clk_en_q !== 1'b1; n++) tick(1);
    chk(nm, 16'(n), 16'(e));
  endtask

  task automatic watch(input int n);
    w_int = 2'h0;
    w_rc = 1'b0;
    w_rst = 1'b0;
    repeat (n)
    begin
      tick(1);
      w_int = w_int | wake_int_q;
      w_rc = w_rc | osc_use_rc_q;
      w_rst = w_rst | sys_reset_q;
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #2000000;
    mismatches++;
    close_out;
  end

  initial
  begin
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    wr_reg(8'h01, 8'h00);
    tick(10);
    wr_reg(8'h01, 8'h08);
    rd_chk("src", 8'h01, 8'h04);
    rd_chk("status", 8'h02, 8'h00);
    tick(40);
    rd_chk("status", 8'h02, 8'h10);
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      tick(60);
      rd_chk("reg", rows[i].a, rows[i].e);
      chk("osc", {osc_use_rc_q, crystal_amp_en_q}, {rows[i].rc, rows[i].amp});
    end
    gap("div4", 1);
    foreach (dv[i])
    begin
      wr_reg(8'h00, dv[i]);
      gap("hold", old_gap[i]);
      tick(2100);
      gap("rate", new_gap[i]);
    end
    wr_reg(8'h00, 8'h20);
    serial_busy <= 1'b1;
    tick(1);
    wr_reg(8'h00, 8'hA0);
    rd_chk("busy", 8'h00, 8'h60);
    serial_busy <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(8'h00, 8'hA0);
      tick(40);
      tx_buf_write <= (i == 0);
      ext_int_ack <= (i == 2);
      rx_enable <= (i == 1);
      rx_pin <= !(i == 1 || i == 3);
      tick(4);
      tx_buf_write <= 1'b0;
      ext_int_ack <= 1'b0;
      rx_pin <= 1'b1;
      tick(40);
      rd_chk("swb", 8'h00, (i == 3) ? 8'hA0 : 8'h60);
    end
    wr_reg(8'h00, 8'h40);
    tick(300);
    wr_reg(8'h03, 8'h01);
    tick(4);
    chk("idle", strobe_force_high_q, 1'b1);
    int_pending <= 1'b1;
    tick(1);
    int_pending <= 1'b0;
    tick(4);
    chk("idle end", strobe_force_high_q, 1'b0);
    rd_chk("power_control_reg", 8'h03, 8'h00);
    // a write while the clock enable is low must not be taken
    ce <= 1'b0;
    wr_reg(8'h00, 8'h80);
    ce <= 1'b1;
    rd_chk("ce freeze", 8'h00, 8'h40);
    ext_prog_mem <= 1'b1;
    int_level_mode <= 2'h3;
    int_enable <= 2'h3;
    global_int_enable <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'h01, (i == 1) ? 8'h0A : 8'h08);
      wr_reg(8'h03, 8'h02);
      instr_end <= 1'b1;
      tick(1);
      instr_end <= 1'b0;
      tick(6);
      chk("pd", {power_down_q, strobe_force_low_q, port0_float_q}, 3'h7);
      ext_int_n_pin <= (i == 1) ? 2'h1 : 2'h2;
      watch(20);
      chk("wake", {w_rc, w_int, power_down_q}, {i[0], 2'h1 << i, 1'b0});
      ext_int_n_pin <= 2'h3;
      tick(100);
      chk("xtal back", osc_use_rc_q, 1'b0);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(8'h00, 8'h80);
      tick(100);
      if (i == 2)
        wr_reg(8'h03, 8'h02);
      instr_end <= 1'b1;
      tick(1);
      instr_end <= 1'b0;
      tick(4);
      wdt_reset_req <= (i == 0);
      rst_pin <= (i != 0);
      tick(1);
      wdt_reset_req <= 1'b0;
      watch(150);
      rst_pin <= 1'b0;
      tick(50);
      chk("reset", {w_rst, power_down_q}, 2'h2);
      rd_chk("div reset", 8'h00, 8'h40);
    end
    close_out;
  end
endmodule
